// >>> rtl/dcf_map.svh
// Constants for the dual-clock programmable-flag FIFO
`ifndef DCF_MAP_SVH
`define DCF_MAP_SVH

`define DCF_DATA_W        9
`define DCF_DEPTH         16384
`define DCF_OFS_W         9
`define DCF_OFS_HI_POS    9
`define DCF_OFS_CMB_W     18
`define DCF_OFS_COUNT     4
`define DCF_EMPTY_OFS_RST 9'h007
`define DCF_FULL_OFS_RST  9'h007
`define DCF_OFS_HI_RST    9'h000
`define DCF_DOUT_RST      9'h000

`endif

// >>> rtl/dcf_pkg.sv
// Types shared by the dual-clock programmable-flag FIFO
package dcf_pkg;
`include "dcf_map.svh"

    typedef logic [`DCF_DATA_W-1:0] dcf_word_t;
    typedef logic [`DCF_OFS_CMB_W-1:0] dcf_ofs_t;

    typedef enum logic {
        DCF_MODE_TWO_EN = 1'b0,
        DCF_MODE_PROG   = 1'b1
    } dcf_mode_e;

    typedef enum logic [1:0] {
        DCF_SEL_EMPTY_LO = 2'b00,
        DCF_SEL_EMPTY_HI = 2'b01,
        DCF_SEL_FULL_LO  = 2'b10,
        DCF_SEL_FULL_HI  = 2'b11
    } dcf_sel_e;

    typedef struct packed {
        logic      wclk;
        logic      rclk;
        dcf_word_t data;
        logic      writeGatePrimaryN;
        logic      writeGateSecondOrLoad;
        logic      readGatePrimaryN;
        logic      readGateSecondN;
        logic      outEnN;
    } dcf_pins_s;

    typedef struct packed {
        logic emptyN;
        logic fullN;
        logic almostEmptyN;
        logic almostFullN;
    } dcf_flags_s;

endpackage

// >>> rtl/dcf_pin_sync.sv
// Two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module dcf_pin_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] pinIn,
    output logic      [W-1:0] synced
);

    logic [W-1:0] meta;

    // No reset: the pins may toggle at any time
    always_ff @(posedge clk) begin
        meta <= pinIn;
    end

    always_ff @(posedge clk) begin
        synced <= meta;
    end

endmodule

// >>> rtl/dcf_offset_bank.sv
// Four threshold registers walked by a shared sequence pointer
`timescale 1ns/1ps
module dcf_offset_bank
    import dcf_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      rstn,
    input  wire logic      wrStb,
    input  wire logic      rdStb,
    input  wire dcf_word_t wrData,
    output dcf_ofs_t       emptyOfs,
    output dcf_ofs_t       fullOfs,
    output dcf_word_t      rdData
);

    dcf_word_t ofs [`DCF_OFS_COUNT];
    dcf_sel_e  sel;
    dcf_sel_e  next_sel;

    ////////////////////////////////////////////////////////////////////////
    // Sequence pointer, kept across load sessions

    always_comb begin
        case (sel)
            DCF_SEL_EMPTY_LO: next_sel = DCF_SEL_EMPTY_HI;
            DCF_SEL_EMPTY_HI: next_sel = DCF_SEL_FULL_LO;
            DCF_SEL_FULL_LO:  next_sel = DCF_SEL_FULL_HI;
            DCF_SEL_FULL_HI:  next_sel = DCF_SEL_EMPTY_LO;
            default:          next_sel = DCF_SEL_EMPTY_LO;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            sel <= DCF_SEL_EMPTY_LO;
        end else if (wrStb || rdStb) begin
            sel <= next_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register storage

    for (genvar i = 0; i < `DCF_OFS_COUNT; i++) begin : g_ofs
        localparam dcf_word_t RST = (i == 0) ? `DCF_EMPTY_OFS_RST :
                                    (i == 2) ? `DCF_FULL_OFS_RST :
                                               `DCF_OFS_HI_RST;
        always_ff @(posedge clk) begin
            if (!rstn) begin
                ofs[i] <= RST;
            end else if (wrStb && sel == 2'(i)) begin
                ofs[i] <= wrData;
            end
        end
    end

    assign emptyOfs = {ofs[1], ofs[0]};
    assign fullOfs  = {ofs[3], ofs[2]};
    assign rdData   = ofs[sel];

endmodule

// >>> rtl/dcf_fifo.sv
// Dual-clock FIFO with two enables or programmable almost flags
//
// Operation
// - Two-enable mode: write when gates and room
// - Flag mode: primary enable alone gates writes
// - Load pin during reset picks the mode
// - Writes sequential, independent of reads
// - Both read enables low and data: next word
// - Output enable high floats data outputs
// - Only read-enabled device drives data
// - Full ignores writes, empty ignores reads
// - Empty keeps last valid word on outputs
// - Load writes four offsets in fixed order
// - Partial load resumes at next register
// - Load plus read enables reads offsets
// - Almost empty low at count up to n
// - Almost full low at depth minus m
// - Default offsets are seven
// - Full flag on write edges, blocks writes
// - Empty flag on read edges, blocks reads
// - Reset empties, outputs low, no traffic
`timescale 1ns/1ps
module dcf_fifo
    import dcf_pkg::*;
#(
    parameter int DEPTH = `DCF_DEPTH
) (
    input  wire logic      clk,
    input  wire logic      rstn,
    input  wire logic      wclk,
    input  wire logic      rclk,
    input  wire dcf_word_t dataIn,
    input  wire logic      writeGatePrimaryN,
    input  wire logic      writeGateSecondOrLoad,
    input  wire logic      readGatePrimaryN,
    input  wire logic      readGateSecondN,
    input  wire logic      outEnN,
    output dcf_word_t      dataOut,
    output logic           dataOutOeN,
    output logic           emptyFlagN,
    output logic           fullFlagN,
    output logic           almostEmptyFlagN,
    output logic           almostFullFlagN
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);
    localparam logic [AW:0] ONE_C = (AW + 1)'(1);

    ////////////////////////////////////////////////////////////////////////
    // Pin capture

    dcf_pins_s pinsRaw;
    dcf_pins_s pins;
    logic      wclkPrev;
    logic      rclkPrev;
    logic      wrEdge;
    logic      rdEdge;

    assign pinsRaw = '{
        wclk:                  wclk,
        rclk:                  rclk,
        data:                  dataIn,
        writeGatePrimaryN:     writeGatePrimaryN,
        writeGateSecondOrLoad: writeGateSecondOrLoad,
        readGatePrimaryN:      readGatePrimaryN,
        readGateSecondN:       readGateSecondN,
        outEnN:                outEnN
    };

    // Data and gates share the clocks' latency, so they stay aligned
    dcf_pin_sync #(
        .W      ($bits(dcf_pins_s))
    ) u_sync (
        .clk    (clk),
        .pinIn  (pinsRaw),
        .synced (pins)
    );

    always_ff @(posedge clk) begin
        wclkPrev <= pins.wclk;
    end

    always_ff @(posedge clk) begin
        rclkPrev <= pins.rclk;
    end

    assign wrEdge = pins.wclk & ~wclkPrev;
    assign rdEdge = pins.rclk & ~rclkPrev;

    ////////////////////////////////////////////////////////////////////////
    // Mode caught while reset is held

    dcf_mode_e mode;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            mode <= pins.writeGateSecondOrLoad ? DCF_MODE_TWO_EN
                                               : DCF_MODE_PROG;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Request decode

    dcf_flags_s flags;
    logic       loadLow;
    logic       readGated;
    logic       fifoWr;
    logic       fifoRd;
    logic       ofsWr;
    logic       ofsRd;

    // Load pin counts as load only in flag mode
    assign loadLow   = (mode == DCF_MODE_PROG) & ~pins.writeGateSecondOrLoad;
    assign readGated = ~pins.readGatePrimaryN & ~pins.readGateSecondN;

    assign fifoWr = wrEdge & rstn & flags.fullN
                  & ~pins.writeGatePrimaryN & pins.writeGateSecondOrLoad;

    assign ofsWr  = wrEdge & rstn & loadLow & ~pins.writeGatePrimaryN;

    assign ofsRd  = rdEdge & rstn & loadLow & readGated & ~ofsWr;

    assign fifoRd = rdEdge & rstn & ~loadLow & readGated & flags.emptyN;

    ////////////////////////////////////////////////////////////////////////
    // Storage array and pointers

    dcf_word_t   mem [DEPTH];
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
    logic [AW:0] next_wrPtr;
    logic [AW:0] next_rdPtr;
    logic [AW:0] next_count;

    assign next_wrPtr = fifoWr ? wrPtr + ONE_C : wrPtr;
    assign next_rdPtr = fifoRd ? rdPtr + ONE_C : rdPtr;
    assign next_count = next_wrPtr - next_rdPtr;

    always_ff @(posedge clk) begin
        if (fifoWr) begin
            mem[wrPtr[AW-1:0]] <= pins.data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            wrPtr <= '0;
        end else begin
            wrPtr <= next_wrPtr;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdPtr <= '0;
        end else begin
            rdPtr <= next_rdPtr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Threshold registers

    dcf_ofs_t  emptyOfs;
    dcf_ofs_t  fullOfs;
    dcf_word_t ofsRdData;

    dcf_offset_bank u_ofs (
        .clk      (clk),
        .rstn     (rstn),
        .wrStb    (ofsWr),
        .rdStb    (ofsRd),
        .wrData   (pins.data),
        .emptyOfs (emptyOfs),
        .fullOfs  (fullOfs),
        .rdData   (ofsRdData)
    );

    ////////////////////////////////////////////////////////////////////////
    // Flags

    dcf_ofs_t countWide;
    dcf_ofs_t freeWide;

    assign countWide = `DCF_OFS_CMB_W'(next_count);
    assign freeWide  = `DCF_OFS_CMB_W'(DEPTH_C - next_count);

    always_ff @(posedge clk) begin
        if (!rstn) begin
            flags.emptyN <= 1'b0;
        end else if (rdEdge) begin
            flags.emptyN <= (next_count != '0);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            flags.fullN <= 1'b1;
        end else if (wrEdge) begin
            flags.fullN <= (next_count != DEPTH_C);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            flags.almostEmptyN <= 1'b0;
        end else if (rdEdge) begin
            flags.almostEmptyN <= (countWide > emptyOfs);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            flags.almostFullN <= 1'b1;
        end else if (wrEdge) begin
            flags.almostFullN <= (freeWide > fullOfs);
        end
    end

    assign emptyFlagN       = flags.emptyN;
    assign fullFlagN        = flags.fullN;
    assign almostEmptyFlagN = flags.almostEmptyN;
    assign almostFullFlagN  = flags.almostFullN;

    ////////////////////////////////////////////////////////////////////////
    // Output register and drive

    always_ff @(posedge clk) begin
        if (!rstn) begin
            dataOut <= `DCF_DOUT_RST;
        end else if (fifoRd) begin
            dataOut <= mem[rdPtr[AW-1:0]];
        end else if (ofsRd) begin
            dataOut <= ofsRdData;
        end
    end

    // Pins float in reset to avoid contention on a shared bus
    // output enable drive
    always_ff @(posedge clk) begin
        if (!rstn) begin
            dataOutOeN <= 1'b1;
        end else begin
            dataOutOeN <= pins.outEnN | ~readGated;
        end
    end

endmodule

// >>> sim/dcf_far_side.sv
// Writer and reader logic on the far side of the FIFO pins
`timescale 1ns/1ps
module dcf_far_side
    import dcf_pkg::*;
(
    input  wire logic clk,
    output dcf_pins_s pins
);
    initial begin
        pins = {2'b00, 9'h000, 5'h1E};
    end
    ////////////////////////////////////////
    // one access at a time
    task automatic wr(input dcf_word_t d, input logic g1, input int hi);
        @(negedge clk);
        pins.data = d;
        pins.writeGatePrimaryN = g1;
        repeat (2) @(negedge clk);
        pins.wclk = 1'b1;
        repeat (hi) @(negedge clk);
        pins.wclk = 1'b0;
        @(negedge clk);
        pins.writeGatePrimaryN = 1'b1;
        // Released bus never shows a stale word
        pins.data = ~d;
        repeat (2) @(negedge clk);
    endtask
    task automatic rd(input logic g1, input logic g2, input int hi);
        @(negedge clk);
        pins.readGatePrimaryN = g1;
        pins.readGateSecondN = g2;
        repeat (2) @(negedge clk);
        pins.rclk = 1'b1;
        repeat (hi) @(negedge clk);
        pins.rclk = 1'b0;
        repeat (3) @(negedge clk);
    endtask
    task automatic set(input logic ld, input logic oe);
        @(negedge clk);
        pins.writeGateSecondOrLoad = ld;
        pins.outEnN = oe;
        repeat (4) @(negedge clk);
    endtask
endmodule

// >>> sim/dcf_fifo_assertions.sv
// Pin-level checker for the dual-clock FIFO
`timescale 1ns/1ps
module dcf_fifo_assertions
    import dcf_pkg::*;
#(
    parameter int DEPTH = 16384
) (
    input wire logic      clk,
    input wire logic      rstn,
    input wire logic      wclk,
    input wire logic      rclk,
    input wire dcf_word_t dataIn,
    input wire logic      writeGatePrimaryN,
    input wire logic      writeGateSecondOrLoad,
    input wire logic      readGatePrimaryN,
    input wire logic      readGateSecondN,
    input wire logic      outEnN,
    input wire dcf_word_t dataOut,
    input wire logic      dataOutOeN,
    input wire logic      emptyFlagN,
    input wire logic      fullFlagN,
    input wire logic      almostEmptyFlagN,
    input wire logic      almostFullFlagN
);
    logic [2:0] wSeen;
    logic [2:0] rSeen;
    logic       wQuiet;
    logic       rQuiet;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    always_ff @(posedge clk) begin
        wSeen <= {wSeen[1:0], wclk};
    end
    always_ff @(posedge clk) begin
        rSeen <= {rSeen[1:0], rclk};
    end
    // Wide window so a one-cycle skew cannot fire falsely
    assign wQuiet = (&{wclk, wSeen}) | ~(|{wclk, wSeen});
    assign rQuiet = (&{rclk, rSeen}) | ~(|{rclk, rSeen});
    ////////////////////////////////////////
    reset_values_a:
        assert property (disable iff (1'b0) !rstn |=> dataOut == 9'h000
            && dataOutOeN && !emptyFlagN && fullFlagN
            && !almostEmptyFlagN && almostFullFlagN)
        else $error("outputs not at reset values");
    empty_hold_a:
        assert property (rQuiet |=> $stable(emptyFlagN))
        else $error("empty flag moved without read clock");
    almost_empty_hold_a:
        assert property (rQuiet |=> $stable(almostEmptyFlagN))
        else $error("almost empty moved without read clock");
    full_hold_a:
        assert property (wQuiet |=> $stable(fullFlagN))
        else $error("full flag moved without write clock");
    almost_full_hold_a:
        assert property (wQuiet |=> $stable(almostFullFlagN))
        else $error("almost full moved without write clock");
    data_hold_a:
        assert property (rQuiet |=> $stable(dataOut))
        else $error("data output moved without read clock");
    oe_float_a:
        assert property (outEnN [*4] |-> dataOutOeN)
        else $error("outputs driven with enable high");
    cascade_float_a:
        assert property (readGatePrimaryN [*4] |-> dataOutOeN)
        else $error("outputs driven while not read enabled");
    empty_order_a:
        assert property (!emptyFlagN |-> !almostEmptyFlagN)
        else $error("empty without almost empty");
    full_order_a:
        assert property (!fullFlagN |-> !almostFullFlagN)
        else $error("full without almost full");
    cover property (!fullFlagN);
    cover property (!dataOutOeN ##1 dataOutOeN);
    cover property ($rose(almostEmptyFlagN));
endmodule

bind dcf_fifo dcf_fifo_assertions #(.DEPTH(DEPTH)) dcf_fifo_assertions_i (
    .clk(clk), .rstn(rstn), .wclk(wclk), .rclk(rclk), .dataIn(dataIn),
    .writeGatePrimaryN(writeGatePrimaryN),
    .writeGateSecondOrLoad(writeGateSecondOrLoad),
    .readGatePrimaryN(readGatePrimaryN),
    .readGateSecondN(readGateSecondN), .outEnN(outEnN),
    .dataOut(dataOut), .dataOutOeN(dataOutOeN),
    .emptyFlagN(emptyFlagN), .fullFlagN(fullFlagN),
    .almostEmptyFlagN(almostEmptyFlagN), .almostFullFlagN(almostFullFlagN)
);

// >>> sim/testbench.sv
// Self-checking bench for the dual-clock FIFO
`timescale 1ns/1ps
module testbench
    import dcf_pkg::*;
;
    localparam int D = 16;
    logic       clk;
    logic       rstn;
    dcf_pins_s  pins;
    dcf_flags_s fl;
    dcf_word_t  dataOut;
    logic       oeN;
    int         miscompares;
    int         samplesChecked;
    dcf_word_t  offs [4] = '{9'h002, 9'h000, 9'h003, 9'h000};

    dcf_far_side dcf_far_side_i (.clk(clk), .pins(pins));
    dcf_fifo #(.DEPTH(D)) dcf_fifo_i (
        .clk(clk), .rstn(rstn), .wclk(pins.wclk), .rclk(pins.rclk),
        .dataIn(pins.data),
        .writeGatePrimaryN(pins.writeGatePrimaryN),
        .writeGateSecondOrLoad(pins.writeGateSecondOrLoad),
        .readGatePrimaryN(pins.readGatePrimaryN),
        .readGateSecondN(pins.readGateSecondN), .outEnN(pins.outEnN),
        .dataOut(dataOut), .dataOutOeN(oeN), .emptyFlagN(fl.emptyN),
        .fullFlagN(fl.fullN), .almostEmptyFlagN(fl.almostEmptyN),
        .almostFullFlagN(fl.almostFullN)
    );
    ////////////////////////////////////////
    task automatic chk(input dcf_word_t got, input dcf_word_t exp);
        samplesChecked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic printVerdict();
        $display("checked %0d, mismatches %0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic doReset(input logic ld);
        @(negedge clk);
        rstn = 1'b0;
        dcf_far_side_i.set(ld, 1'b0);
        @(negedge clk);
        rstn = 1'b1;
        repeat (2) @(negedge clk);
        chk({5'h00, fl}, {5'h00, 4'b0101});
        chk(dataOut, 9'h000);
    endtask
    task automatic fillDrain(input int n, input int m, input dcf_word_t last);
        for (int i = 1; i <= D; i++) begin
            dcf_far_side_i.wr(dcf_word_t'(9'h0A0 + i), 1'b0, 2 + i % 4);
            chk({7'h00, fl.fullN, fl.almostFullN},
                {7'h00, i < D, D - i > m});
        end
        dcf_far_side_i.wr(9'h1FF, 1'b0, 2);
        chk({8'h00, fl.fullN}, 9'h000);
        dcf_far_side_i.rd(1'b0, 1'b1, 2);
        chk(dataOut, last);
        for (int i = 1; i <= D; i++) begin
            dcf_far_side_i.rd(1'b0, 1'b0, 2 + i % 3);
            chk(dataOut, dcf_word_t'(9'h0A0 + i));
            chk({6'h00, fl.emptyN, fl.almostEmptyN, oeN},
                {6'h00, i < D, D - i > n, 1'b0});
        end
        dcf_far_side_i.rd(1'b0, 1'b0, 2);
        chk(dataOut, 9'h0B0);
        chk({8'h00, fl.emptyN}, 9'h000);
        dcf_far_side_i.set(1'b1, 1'b1);
        chk({8'h00, oeN}, 9'h001);
        dcf_far_side_i.set(1'b1, 1'b0);
        dcf_far_side_i.rd(1'b1, 1'b0, 2);
        chk({8'h00, oeN}, 9'h001);
    endtask
    ////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        printVerdict();
    end
    initial begin
        rstn = 1'b0;
        miscompares = 0;
        samplesChecked = 0;
        doReset(1'b1);
        dcf_far_side_i.set(1'b0, 1'b0);
        dcf_far_side_i.wr(9'h155, 1'b0, 2);
        dcf_far_side_i.set(1'b1, 1'b0);
        dcf_far_side_i.rd(1'b0, 1'b0, 2);
        chk({8'h00, fl.emptyN}, 9'h000);
        fillDrain(7, 7, 9'h000);
        doReset(1'b0);
        dcf_far_side_i.wr(9'h055, 1'b1, 2);
        dcf_far_side_i.wr(offs[0], 1'b0, 2);
        dcf_far_side_i.wr(offs[1], 1'b0, 3);
        dcf_far_side_i.set(1'b1, 1'b0);
        dcf_far_side_i.set(1'b0, 1'b0);
        dcf_far_side_i.wr(offs[2], 1'b0, 5);
        dcf_far_side_i.wr(offs[3], 1'b0, 2);
        for (int k = 0; k < 4; k++) begin
            dcf_far_side_i.rd(1'b0, 1'b0, 2);
            chk(dataOut, offs[k]);
        end
        dcf_far_side_i.set(1'b1, 1'b0);
        fillDrain(2, 3, 9'h000);
        printVerdict();
    end
endmodule
